/* pkg/ulpi_phy_event_params.svh */
// Offsets, field positions, reset values and command codes of the event register bank
`ifndef ULPI_PHY_EVENT_PARAMS_SVH
`define ULPI_PHY_EVENT_PARAMS_SVH
// Register addresses (6-bit ULPI address space)
`define ADDR_RISE_WR      6'h0D
`define ADDR_RISE_SET     6'h0E
`define ADDR_RISE_CLR     6'h0F
`define ADDR_FALL_WR      6'h10
`define ADDR_FALL_SET     6'h11
`define ADDR_FALL_CLR     6'h12
`define ADDR_LIVE         6'h13
`define ADDR_LATCH        6'h14
`define ADDR_DEBUG        6'h15
`define ADDR_SCRATCH_WR   6'h16
`define ADDR_SCRATCH_SET  6'h17
`define ADDR_SCRATCH_CLR  6'h18
// Reset values
`define RISE_EN_RESET     5'h1F
`define FALL_EN_RESET     5'h1F
`define LIVE_RESET        5'h00
`define LATCH_RESET       5'h00
`define SCRATCH_RESET     8'h00
// Event source bit positions
`define EVT_HOST_DISC     0
`define EVT_VBUS_VALID    1
`define EVT_SESS_VALID    2
`define EVT_SESS_END      3
`define EVT_ID_GND        4
`define EVT_COUNT         5
// Command class in bits 7:6
`define CMD_IDLE          2'h0
`define CMD_TRANSMIT      2'h1
`define CMD_REG_WRITE     2'h2
`define CMD_REG_READ      2'h3
`define CMD_IDLE_BYTE     8'h00
`define NOPID_LOW         6'h00
`endif

/* pkg/ulpi_phy_event_pkg.sv */
// Types shared by the event register bank
package ulpi_phy_event_pkg;
	// Bus sequencer states
	typedef enum logic [3:0] {
		ST_IDLE, ST_WR_ACK, ST_WR_DATA, ST_WR_STOP, ST_WR_COMMIT,
		ST_RD_ACK, ST_RD_TURN, ST_RD_DRIVE, ST_RX_TURN, ST_RX_DRIVE, ST_TX
	} seq_state_e;
	// Comparator and detach levels
	typedef struct packed {
		logic id_grounded_flag;
		logic session_end_flag;
		logic session_valid_flag;
		logic vbus_valid;
		logic host_disconnect;
	} event_levels_s;
	// Decoded transmit request toward the USB transmitter
	typedef struct packed {
		logic       start;
		logic       nopid;
		logic [3:0] pid;
	} tx_request_s;
endpackage : ulpi_phy_event_pkg

/* rtl/ulpi_phy_event_registers.sv */
// ULPI command decode and event register bank of the transceiver
// Functional notes
// RULE_01: Falling enable bits 0-4 arm falls, reset one
// RULE_02: Falling enable at 10h/11h/12h, bits 7:5 zero
// RULE_03: 13h returns live five levels, reset zero
// RULE_04: Enabled transition sets matching latch bit at 14h
// RULE_05: Reading 14h clears latch; reserved bits zero
// RULE_06: 15h returns line level bits, rest zero
// RULE_07: Scratch at 16h-18h, reset 00h, no effect
// RULE_08: Link avoids vendor range 30h to 3Fh
// RULE_09: Link avoids carkit and extended ranges
// RULE_10: Link sends command only while direction low
// RULE_11: Command class taken from bits 7:6
// RULE_12: 01b with 000000b is transmit without identifier
// RULE_13: 01b with 00XXXXb carries identifier in 3:0
// RULE_14: 10b starts register write to bits 5:0
// RULE_15: 11b starts register read of bits 5:0
// RULE_16: Rising enable at 0Dh arms rises, reset one
// RULE_17: Latched event sends receive command when bus owned
// RULE_18: Write data commits after stop deasserts
// RULE_19: Set alias ORs, clear alias clears, reads same
// RULE_20: Zero byte while not driving is idle
`timescale 1ns/100ps
`include "ulpi_phy_event_params.svh"
module ulpi_phy_event_registers (
	input  wire logic                              clk_i,
	input  wire logic                              rst_b_i,
	input  wire logic [7:0]                        data_i,
	output logic [7:0]                             data_o,
	output logic                                   data_oe_o,
	output logic                                   dir_o,
	output logic                                   nxt_o,
	input  wire logic                              stp_i,
	input  wire ulpi_phy_event_pkg::event_levels_s levels_i,
	input  wire logic                              line_level_bit0_i,
	input  wire logic                              line_level_bit1_i,
	output ulpi_phy_event_pkg::tx_request_s        tx_request_o
);
	import ulpi_phy_event_pkg::*;

	seq_state_e       state_reg;       // Bus sequencer state
	logic [5:0]       addr_reg;        // Register address of current access
	logic [7:0]       wdata_reg;       // Captured write data
	logic [4:0]       rise_en_reg;     // Rising-edge enables
	logic [4:0]       fall_en_reg;     // Falling-edge enables
	logic [4:0]       live_reg;        // Registered live levels
	logic [4:0]       latch_reg;       // Latched events
	logic [7:0]       scratch_reg;     // Scratch byte
	logic [1:0]       line_reg;        // Registered line levels
	logic             pending_reg;     // Receive command owed to link
	logic [4:0]       live_next;       // Present levels as a vector
	logic [4:0]       event_set;       // Enabled transitions this cycle
	logic             commit;          // Write data is committed now
	logic             read_latch;      // Latch register is read now
	logic [7:0]       read_byte;       // Read multiplexer output
	logic [7:0]       rx_byte;         // Receive command byte
	logic [1:0]       vbus_code;       // Encoded supply state

	// Present levels packed into bit order of the status registers
	assign live_next = levels_i;

	// Enabled rises and falls against the previous sample
	assign event_set = (live_next & ~live_reg & rise_en_reg)   // RULE_16
		| (~live_next & live_reg & fall_en_reg);              // RULE_01

	// Commit only once the link has lowered stop
	assign commit = (state_reg == ST_WR_COMMIT) && !stp_i;   // RULE_18

	// The value is taken for the bus in the turnaround cycle
	assign read_latch = (state_reg == ST_RD_TURN) && (addr_reg == `ADDR_LATCH);

	// Set and clear aliases share one merge rule
	function automatic logic [7:0] merge(
		input logic [7:0] old_val,
		input logic [1:0] kind,
		input logic [7:0] wr_val
	);
		logic [7:0] res;
		res = old_val;
		unique case (kind)
			2'h0: res = wr_val;              // Direct write
			2'h1: res = old_val | wr_val;    // Set alias
			2'h2: res = old_val & ~wr_val;   // Clear alias
			2'h3: res = old_val;             // Not used
		endcase
		return res;                          // RULE_19
	endfunction : merge

	// Read multiplexer; aliases return the same register
	always_comb
	begin
		read_byte = 8'h00;                   // Unmapped and reserved ranges read zero
		unique case (addr_reg)
			`ADDR_RISE_WR, `ADDR_RISE_SET, `ADDR_RISE_CLR:
				read_byte = {3'h0, rise_en_reg};                 // RULE_16
			`ADDR_FALL_WR, `ADDR_FALL_SET, `ADDR_FALL_CLR:
				read_byte = {3'h0, fall_en_reg};                 // RULE_02
			`ADDR_LIVE:
				read_byte = {3'h0, live_reg};                    // RULE_03
			`ADDR_LATCH:
				read_byte = {3'h0, latch_reg};                   // RULE_05
			`ADDR_DEBUG:
				read_byte = {6'h00, line_reg};                   // RULE_06
			`ADDR_SCRATCH_WR, `ADDR_SCRATCH_SET, `ADDR_SCRATCH_CLR:
				read_byte = scratch_reg;                         // RULE_07
			default:
				read_byte = 8'h00;           // Vendor, carkit and extended ranges are not modelled
		endcase
	end

	// Supply state encoding for the receive command
	always_comb
	begin
		if (live_reg[`EVT_VBUS_VALID])
			vbus_code = 2'h3;
		else if (live_reg[`EVT_SESS_VALID])
			vbus_code = 2'h2;
		else if (!live_reg[`EVT_SESS_END])
			vbus_code = 2'h1;
		else
			vbus_code = 2'h0;
	end

	// Receive command: line state, supply, detach, ID pin level
	assign rx_byte = {1'b0, ~live_reg[`EVT_ID_GND], live_reg[`EVT_HOST_DISC], 1'b0, vbus_code, line_reg};

	// Live level sampling; inputs are synchronous already
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			live_reg <= `LIVE_RESET;
			line_reg <= 2'h0;
		end
		else
		begin
			live_reg <= live_next;                                  // RULE_03
			line_reg <= {line_level_bit1_i, line_level_bit0_i};     // RULE_06
		end
	end

	// Rising and falling enables, direct or through aliases
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rise_en_reg <= `RISE_EN_RESET;   // RULE_16
			fall_en_reg <= `FALL_EN_RESET;   // RULE_01
		end
		else if (commit)
		begin
			if (addr_reg >= `ADDR_RISE_WR && addr_reg <= `ADDR_RISE_CLR)
				rise_en_reg <= 5'(merge({3'h0, rise_en_reg}, 2'(addr_reg - `ADDR_RISE_WR), wdata_reg));
			if (addr_reg >= `ADDR_FALL_WR && addr_reg <= `ADDR_FALL_CLR)
				fall_en_reg <= 5'(merge({3'h0, fall_en_reg}, 2'(addr_reg - `ADDR_FALL_WR), wdata_reg)); // RULE_02
		end
	end

	// Scratch byte; only the read multiplexer reads it
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			scratch_reg <= `SCRATCH_RESET;
		else if (commit && addr_reg >= `ADDR_SCRATCH_WR && addr_reg <= `ADDR_SCRATCH_CLR)
			scratch_reg <= merge(scratch_reg, 2'(addr_reg - `ADDR_SCRATCH_WR), wdata_reg); // RULE_07
	end

	// Event latch; a new event in the read cycle survives the clear
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			latch_reg <= `LATCH_RESET;
		else if (read_latch)
			latch_reg <= event_set;                      // RULE_05
		else
			latch_reg <= latch_reg | event_set;          // RULE_04
	end

	// Owed receive command; set wins over the clear on send
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			pending_reg <= 1'b0;
		else if (|event_set)
			pending_reg <= 1'b1;                         // RULE_17
		else if (state_reg == ST_RX_TURN)
			pending_reg <= 1'b0;
	end

	// Bus sequencer: command decode, turnarounds and handshakes
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg    <= ST_IDLE;
			addr_reg     <= 6'h00;
			wdata_reg    <= 8'h00;
			data_o       <= 8'h00;
			data_oe_o    <= 1'b0;
			dir_o        <= 1'b0;
			nxt_o        <= 1'b0;
			tx_request_o <= '0;
		end
		else
		begin
			tx_request_o.start <= 1'b0;              // Start is a one-cycle pulse
			unique case (state_reg)
				ST_IDLE:
				begin
					// Link commands only arrive while direction is low
					if (data_i == `CMD_IDLE_BYTE)    // RULE_20
					begin
						// Take the bus only when the link is idle
						if (pending_reg && !stp_i)
						begin
							dir_o     <= 1'b1;       // RULE_17
							state_reg <= ST_RX_TURN;
						end
					end
					else
					begin
						addr_reg <= data_i[5:0];
						nxt_o    <= 1'b1;
						unique case (data_i[7:6])    // RULE_11
							`CMD_TRANSMIT:
							begin
								tx_request_o.start <= 1'b1;
								tx_request_o.nopid <= (data_i[5:0] == `NOPID_LOW);  // RULE_12
								tx_request_o.pid   <= data_i[3:0];                   // RULE_13
								state_reg          <= ST_TX;
							end
							`CMD_REG_WRITE:
								state_reg <= ST_WR_ACK;                              // RULE_14
							`CMD_REG_READ:
								state_reg <= ST_RD_ACK;                              // RULE_15
							`CMD_IDLE:
							begin
								// Nonzero byte with idle class is ignored
								nxt_o     <= 1'b0;
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				ST_TX:
				begin
					// Transmitter accepts bytes until stop
					if (stp_i)
					begin
						nxt_o     <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				ST_WR_ACK:
					state_reg <= ST_WR_DATA;     // Link places data after seeing nxt
				ST_WR_DATA:
				begin
					wdata_reg <= data_i;         // RULE_14
					state_reg <= ST_WR_STOP;
				end
				ST_WR_STOP:
				begin
					if (stp_i)
					begin
						nxt_o     <= 1'b0;
						state_reg <= ST_WR_COMMIT;
					end
				end
				ST_WR_COMMIT:
				begin
					// Holding off until stop falls avoids a half-ended transfer
					if (!stp_i)
						state_reg <= ST_IDLE;    // RULE_18
				end
				ST_RD_ACK:
				begin
					nxt_o     <= 1'b0;
					dir_o     <= 1'b1;           // RULE_15
					state_reg <= ST_RD_TURN;
				end
				ST_RD_TURN:
				begin
					data_o    <= read_byte;
					data_oe_o <= 1'b1;
					state_reg <= ST_RD_DRIVE;
				end
				ST_RD_DRIVE:
				begin
					data_oe_o <= 1'b0;
					dir_o     <= 1'b0;
					state_reg <= ST_IDLE;
				end
				ST_RX_TURN:
				begin
					data_o    <= rx_byte;        // RULE_17
					data_oe_o <= 1'b1;
					state_reg <= ST_RX_DRIVE;
				end
				ST_RX_DRIVE:
				begin
					data_oe_o <= 1'b0;
					dir_o     <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;        // Illegal codes recover to idle
			endcase
		end
	end
endmodule : ulpi_phy_event_registers

/* bench/ulpi_event_monitor.sv */
// Port-level protocol checker for the event register bank
`timescale 1ns/100ps
module ulpi_event_monitor (
	input wire logic                              clk_i,
	input wire logic                              rst_b_i,
	input wire logic [7:0]                        data_i,
	input wire logic [7:0]                        data_o,
	input wire logic                              data_oe_o,
	input wire logic                              dir_o,
	input wire logic                              nxt_o,
	input wire logic                              stp_i,
	input wire ulpi_phy_event_pkg::event_levels_s levels_i,
	input wire logic                              line_level_bit0_i,
	input wire logic                              line_level_bit1_i,
	input wire ulpi_phy_event_pkg::tx_request_s   tx_request_o
);
	import ulpi_phy_event_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic idle_c; // Bus owned by the link and no handshake open
	assign idle_c = !dir_o && !nxt_o;
	// Read: acknowledge, turnaround, one data cycle, release
	sequence rd_turn; nxt_o ##1 (dir_o && !nxt_o); endsequence
	sequence rd_back; (dir_o && data_oe_o) ##1 !dir_o; endsequence
	// Receive byte follows its turnaround, then bus goes back
	sequence rx_back; (data_oe_o && !data_o[7]) ##1 !dir_o; endsequence
	AST_WR_NXT: assert property (idle_c && $past(data_i) == 8'h00 && data_i[7:6] == 2'h2 |=> nxt_o && !dir_o)
		else $error("write command not acknowledged");
	AST_RD_SEQ: assert property (idle_c && $past(data_i) == 8'h00 && data_i[7:6] == 2'h3 |=> rd_turn ##1 rd_back)
		else $error("read command sequence wrong");
	AST_TX_REQ: assert property (idle_c && $past(data_i) == 8'h00 && data_i[7:6] == 2'h1 |=>
		tx_request_o.start && nxt_o && tx_request_o.pid == $past(data_i[3:0])
		&& tx_request_o.nopid == ($past(data_i[5:0]) == 6'h00))
		else $error("transmit request decoded wrongly");
	AST_START_PULSE: assert property (tx_request_o.start |=> !tx_request_o.start)
		else $error("transmit start longer than one cycle");
	AST_STOP_END: assert property (nxt_o && !dir_o && stp_i |=> !nxt_o)
		else $error("next not dropped after stop");
	AST_IDLE: assert property (idle_c && data_i == 8'h00 |=> !nxt_o)
		else $error("idle byte acted upon");
	AST_OE_OWN: assert property (data_oe_o |-> dir_o && $past(dir_o))
		else $error("data driven without turnaround");
	AST_RX_CMD: assert property ($rose(dir_o) && !$past(nxt_o) |=> rx_back)
		else $error("receive byte malformed");
	// Any byte toward the link stands for exactly one cycle
	AST_OE_ONE: assert property (data_oe_o |=> !data_oe_o)
		else $error("data driven longer than one cycle");
endmodule : ulpi_event_monitor

/* bench/ulpi_link_model.sv */
// Behavioural link controller issuing commands over the bus
`timescale 1ns/100ps
module ulpi_link_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] data_o,
	input  wire logic       data_oe_o,
	input  wire logic       dir_o,
	input  wire logic       nxt_o,
	output logic [7:0]      bus_o,
	output logic            stp_o
);
	logic [7:0] drv;     // Byte the link drives
	logic       rd_wait; // Read reply expected
	// Turnaround with nobody driving shows the inverse of the last byte
	assign bus_o = data_oe_o ? data_o : dir_o ? ~drv : drv;
	initial
	begin
		drv     = 8'h00;
		stp_o   = 1'b0;
		rd_wait = 1'b0;
	end
	// One transfer; callers never touch vendor, carkit or extended space
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] d);
		int n;
		for (n = 0; n < 50 && dir_o; n++)
			@(negedge clk_i);
		if (n > 0)
			@(negedge clk_i);
		rd_wait = (cmd[7:6] == 2'h3);
		drv     = cmd;
		for (n = 0; n < 20 && !nxt_o; n++)
			@(negedge clk_i);
		@(negedge clk_i);
		if (cmd[7:6] == 2'h3)
		begin
			drv = 8'h00;
			for (n = 0; n < 20 && dir_o; n++)
				@(negedge clk_i);
		end
		else
		begin
			if (cmd[7:6] == 2'h2)
			begin
				drv = d;
				@(negedge clk_i);
			end
			drv   = 8'h00;
			stp_o = 1'b1;
			@(negedge clk_i);
			stp_o = 1'b0;
		end
		rd_wait = 1'b0;
		@(negedge clk_i);
	endtask : xfer
endmodule : ulpi_link_model

/* bench/tb.sv */
// Self-checking bench for the event register bank
`timescale 1ns/100ps
module tb;
	import ulpi_phy_event_pkg::*;
	logic          clk_i, rst_b_i, data_oe_o, dir_o, nxt_o, stp_i;
	logic [7:0]    data_i, data_o, r, s, c;
	event_levels_s levels_i;
	logic          line_level_bit0_i, line_level_bit1_i;
	tx_request_s   tx_request_o;
	logic [7:0]    notes[$]; // Expected answers, oldest first
	logic [7:0]    ra[13] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h07};
	int            num_errors = 0, checked = 0, cycles = 0;
	ulpi_phy_event_registers u_ulpi_phy_event_registers (.clk_i(clk_i), .rst_b_i(rst_b_i), .data_i(data_i),
		.data_o(data_o), .data_oe_o(data_oe_o), .dir_o(dir_o), .nxt_o(nxt_o), .stp_i(stp_i), .levels_i(levels_i),
		.line_level_bit0_i(line_level_bit0_i), .line_level_bit1_i(line_level_bit1_i), .tx_request_o(tx_request_o));
	ulpi_link_model u_ulpi_link_model (.clk_i(clk_i), .data_o(data_o), .data_oe_o(data_oe_o), .dir_o(dir_o),
		.nxt_o(nxt_o), .bus_o(data_i), .stp_o(stp_i));
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		notes.push_back(e);
		u_ulpi_link_model.xfer({2'h3, a}, 8'h00);
	endtask : rd
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		u_ulpi_link_model.xfer({2'h2, a}, d);
	endtask : wr
	// Receive byte owed for the present levels; levels are held steady while one is sent
	function automatic logic [7:0] rx_exp();
		logic [1:0] code;
		code = levels_i.vbus_valid ? 2'h3 : levels_i.session_valid_flag ? 2'h2
			: !levels_i.session_end_flag ? 2'h1 : 2'h0;
		return {1'b0, ~levels_i.id_grounded_flag, levels_i.host_disconnect, 1'b0, code,
			line_level_bit1_i, line_level_bit0_i};
	endfunction : rx_exp
	// Watchdog, and comparison of each answer; sampled mid-cycle, where outputs have settled
	always @(negedge clk_i)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			num_errors++;
			summarize();
		end
		else if (tx_request_o.start === 1'b1)
			check({3'h0, tx_request_o.nopid, tx_request_o.pid}, notes.pop_front());
		else if (data_oe_o === 1'b1 && u_ulpi_link_model.rd_wait)
			check(data_o, notes.pop_front());
		else if (data_oe_o === 1'b1)
			check(data_o, rx_exp());
	end
	initial
	begin
		rst_b_i           = 1'b0;
		levels_i          = '0;
		line_level_bit0_i = 1'b0;
		line_level_bit1_i = 1'b0;
		r                 = 8'($urandom(57));
		repeat (6) @(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		// Reset values of every read address, plus an unmapped one
		foreach (ra[i]) rd(ra[i][5:0], i < 6 ? 8'h1F : 8'h00);
		r = 8'($urandom);
		s = 8'($urandom);
		c = 8'($urandom);
		wr(6'h16, r);
		wr(6'h17, s);
		rd(6'h16, r | s);
		wr(6'h18, c);
		rd(6'h17, (r | s) & ~c);
		wr(6'h10, r);
		rd(6'h12, {3'h0, r[4:0]});
		wr(6'h12, 8'hFF);
		wr(6'h11, 8'h02);
		wr(6'h0F, 8'hFF);
		// Rises while rises are masked latch nothing
		levels_i                                 = 5'h1F;
		{line_level_bit1_i, line_level_bit0_i} = s[1:0];
		rd(6'h13, 8'h1F);
		rd(6'h15, {6'h00, s[1:0]});
		rd(6'h14, 8'h00);
		// Falls latch only where a fall is armed; reading clears
		levels_i = 5'h00;
		rd(6'h14, 8'h02);
		rd(6'h14, 8'h00);
		wr(6'h0E, 8'h1F);
		levels_i = c[4:0];
		rd(6'h14, {3'h0, c[4:0]});
		// Transmit without and with an identifier
		notes.push_back(8'h10);
		u_ulpi_link_model.xfer(8'h40, 8'h00);
		r = {4'h4, 4'($urandom_range(15, 1))};
		notes.push_back({4'h0, r[3:0]});
		u_ulpi_link_model.xfer(r, 8'h00);
		repeat (4) @(negedge clk_i);
		// Reset in mid-run restores enables and scratch; present levels then look like rises
		rst_b_i = 1'b0;
		@(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		rd(6'h11, 8'h1F);
		rd(6'h18, 8'h00);
		rd(6'h13, {3'h0, c[4:0]});
		repeat (6) @(negedge clk_i);
		// A read whose answer never came leaves a note behind
		check(8'(notes.size()), 8'h00);
		summarize();
	end
endmodule : tb
bind ulpi_phy_event_registers ulpi_event_monitor u_ulpi_event_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .dir_o(dir_o), .nxt_o(nxt_o), .stp_i(stp_i),
	.levels_i(levels_i), .line_level_bit0_i(line_level_bit0_i), .line_level_bit1_i(line_level_bit1_i),
	.tx_request_o(tx_request_o));
